// ### design/program_memory_access.sv
`timescale 1ns/1ps
module program_memory_access #(
  parameter int DEPTH = pm_access_pkg::DEPTH_DEF
) (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic [2:0]  fetch_cmd_i,
  input  wire logic [14:0] jump_addr_i,
  input  wire logic [7:0]  wreg_i,
  input  wire logic [1:0]  ptr_wr_lo_i,
  input  wire logic [1:0]  ptr_wr_hi_i,
  input  wire logic [7:0]  ptr_wdata_i,
  input  wire logic        ind_rd_i,
  input  wire logic        ind_wr_i,
  input  wire logic        ind_sel_i,
  input  wire logic [13:0] pm_rdata_i,
  output logic      [14:0] pc_o,
  output logic      [14:0] pm_addr_o,
  output logic             pm_rd_o,
  output logic             fetch_stall_o,
  output logic             ind_pm_o,
  output logic             ind_wr_block_o,
  output logic      [7:0]  wreg_load_data_o,
  output logic             wreg_load_o,
  output logic      [15:0] ptr0_o,
  output logic      [15:0] ptr1_o
);

  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  initial
  begin
    if (DEPTH != 4096 && DEPTH != 8192 && DEPTH != 16384)
      $error("program_memory_access: unsupported depth");
  end

  // ----------------------------------------------------------------
  // pointers
  // ----------------------------------------------------------------
  logic [15:0] ptr_w [pm_access_pkg::PTR_COUNT];

  genvar gi;
  generate
    for (gi = 0; gi < pm_access_pkg::PTR_COUNT; gi++)
    begin : g_ptr
      ptr_reg u_ptr (
        .ref_clk_i (ref_clk_i),
        .rst_b_i   (rst_b_i),
        .wr_lo_i   (ptr_wr_lo_i[gi]),
        .wr_hi_i   (ptr_wr_hi_i[gi]),
        .wdata_i   (ptr_wdata_i),
        .ptr_o     (ptr_w[gi])
      );
    end
  endgenerate

  assign ptr0_o = ptr_w[0];
  assign ptr1_o = ptr_w[1];

  // decode: does a pointer aim at program memory
  function automatic logic is_pm(input logic [15:0] p);
    is_pm = p[pm_access_pkg::PM_SEL_BIT];
  endfunction

  logic [15:0] sel_ptr;
  assign sel_ptr  = ptr_w[ind_sel_i];
  assign ind_pm_o = is_pm(sel_ptr);

  // writes to program space are dropped; the core must not write program memory
  assign ind_wr_block_o = ind_wr_i && is_pm(sel_ptr);

  // ----------------------------------------------------------------
  // program counter
  // ----------------------------------------------------------------
  logic [14:0] pc_d;
  logic [14:0] pc_q;
  logic [14:0] pc_raw;
  logic [14:0] pc_wrapped;
  logic [14:0] rd_addr_raw;
  logic [14:0] rd_addr_w;

  pc_wrap #(.DEPTH(DEPTH)) u_wrap_pc (
    .addr_i (pc_raw),
    .addr_o (pc_wrapped)
  );

  // low pointer bits address the word; bit 15 is only the space flag
  assign rd_addr_raw = sel_ptr[14:0];

  pc_wrap #(.DEPTH(DEPTH)) u_wrap_rd (
    .addr_i (rd_addr_raw),
    .addr_o (rd_addr_w)
  );

  // ----------------------------------------------------------------
  // indirect program read sequencer
  // ----------------------------------------------------------------
  pm_access_pkg::rd_state_e rd_st_d;
  pm_access_pkg::rd_state_e rd_st_q;
  logic [7:0]               ld_data_d;
  logic [7:0]               ld_data_q;
  logic                     ld_d;
  logic                     ld_q;

  // extra cycle: the core stalls while the word is fetched
  always_comb
  begin
    rd_st_d   = rd_st_q;
    ld_data_d = ld_data_q;
    ld_d      = 1'b0;
    case (rd_st_q)
      pm_access_pkg::ST_RUN:
      begin
        if (ind_rd_i && is_pm(sel_ptr))
          rd_st_d = pm_access_pkg::ST_PMREAD;
      end
      pm_access_pkg::ST_PMREAD:
      begin
        ld_data_d = pm_rdata_i[7:0];
        ld_d      = 1'b1;
        rd_st_d   = pm_access_pkg::ST_RUN;
      end
      default:
        rd_st_d = pm_access_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rd_st_q   <= pm_access_pkg::ST_RUN;
      ld_data_q <= pm_access_pkg::WREG_RST;
      ld_q      <= 1'b0;
    end
    else
    begin
      rd_st_q   <= rd_st_d;
      ld_data_q <= ld_data_d;
      ld_q      <= ld_d;
    end
  end

  assign fetch_stall_o    = (rd_st_q == pm_access_pkg::ST_PMREAD);
  assign wreg_load_data_o = ld_data_q;
  assign wreg_load_o      = ld_q;

  // ----------------------------------------------------------------
  // next program counter
  // ----------------------------------------------------------------
  // counter holds while the extra read cycle runs
  always_comb
  begin
    pc_raw = pc_q;
    case (pm_access_pkg::fetch_cmd_e'(fetch_cmd_i))
      pm_access_pkg::CMD_NONE:
        pc_raw = pc_q;
      pm_access_pkg::CMD_STEP:
        pc_raw = 15'(pc_q + 15'h0001);
      pm_access_pkg::CMD_JUMP:
        pc_raw = jump_addr_i;
      pm_access_pkg::CMD_BRW:
        pc_raw = 15'(pc_q + 15'h0001 + {7'h00, wreg_i});
      pm_access_pkg::CMD_IRQ:
        pc_raw = pm_access_pkg::INT_VECTOR;
      default:
        pc_raw = pc_q;
    endcase
    if (fetch_stall_o)
      pc_raw = pc_q;
  end

  // wrap sits after the mux so every source folds the same way
  assign pc_d = pc_wrapped;

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      pc_q <= pm_access_pkg::RESET_VECTOR;
    else
      pc_q <= pc_d;
  end

  assign pc_o = pc_q;

  // memory port: read address during the extra cycle, else fetch
  assign pm_addr_o = fetch_stall_o ? rd_addr_w : pc_q;
  assign pm_rd_o   = 1'b1;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  localparam logic [14:0] LAST_A = 15'(DEPTH - 1);

  // counter never leaves the implemented space
  a_pc_in_range: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    pc_q <= LAST_A) else $error("pc beyond implemented depth");

  // first edge after release still shows the reset vector
  a_reset_vector: assert property (@(posedge ref_clk_i)
    $rose(rst_b_i) |-> pc_q == pm_access_pkg::RESET_VECTOR)
    else $error("fetch did not start at reset vector");

  // interrupt lands on its vector whatever the counter held
  a_irq_vector: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (fetch_cmd_i == 3'b100 && !fetch_stall_o) |=> pc_q == 15'h0004)
    else $error("interrupt did not reach vector");

  // step folds back to zero at the top of the space
  a_step_inc: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (fetch_cmd_i == 3'b001 && !fetch_stall_o) |=> pc_q == ((($past(pc_q) + 15'h0001)) & LAST_A))
    else $error("step did not advance");

  // a zero command is a hold, never a step
  a_none_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (fetch_cmd_i == 3'b000) |=> $stable(pc_q))
    else $error("counter moved without a command");

  // jump targets above the depth fold like the counter does
  a_jump_wrap: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (fetch_cmd_i == 3'b010 && !fetch_stall_o) |=> pc_q == ($past(jump_addr_i) & LAST_A))
    else $error("jump target not wrapped");

  // table index: counter plus one plus working register
  a_brw_add: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (fetch_cmd_i == 3'b011 && !fetch_stall_o)
    |=> pc_q == 15'((($past(pc_q) + 15'h0001 + {7'h00, $past(wreg_i)})) & LAST_A))
    else $error("branch by working register wrong");

  // program reads cost exactly one stall cycle
  a_extra_cycle: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (ind_rd_i && ind_pm_o && !fetch_stall_o) |=> fetch_stall_o ##1 (!fetch_stall_o && wreg_load_o))
    else $error("program read not one extra cycle");

  // plain data reads never stall the core
  a_data_no_stall: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (ind_rd_i && !ind_pm_o && !fetch_stall_o) |=> !fetch_stall_o)
    else $error("data read stalled fetch");

  // only the low byte of the word reaches the core
  a_low_byte: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    fetch_stall_o |=> wreg_load_data_o == $past(pm_rdata_i[7:0]))
    else $error("loaded byte is not low byte");

  // one load strobe per read, never stretched
  a_load_pulse: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    wreg_load_o |=> !wreg_load_o)
    else $error("load strobe longer than one cycle");

  // writes aimed at program space are flagged for the core to drop
  a_write_block: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (ind_wr_i && ind_pm_o) |-> ind_wr_block_o)
    else $error("program memory write not blocked");

  // data space writes must not be flagged
  a_write_pass: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (ind_wr_i && !ind_pm_o) |-> !ind_wr_block_o)
    else $error("data write wrongly blocked");

  // stall cycle addresses memory from the selected pointer
  a_rd_addr: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    fetch_stall_o |-> pm_addr_o == (sel_ptr[14:0] & LAST_A))
    else $error("read address not from pointer");

  // outside the stall the memory sees the counter
  a_fetch_addr: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    !fetch_stall_o |-> pm_addr_o == pc_q)
    else $error("fetch address not the counter");

  // counter frozen while the extra cycle runs
  a_pc_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    fetch_stall_o |=> $stable(pc_q))
    else $error("counter moved during extra cycle");

  // a pointer byte write lands in the addressed byte
  a_ptr0_low: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    ptr_wr_lo_i[0] |=> ptr0_o[7:0] == $past(ptr_wdata_i))
    else $error("pointer 0 low byte not written");

  a_ptr1_high: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    ptr_wr_hi_i[1] |=> ptr1_o[15:8] == $past(ptr_wdata_i))
    else $error("pointer 1 high byte not written");

  // pointers only change when written
  a_ptr_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (ptr_wr_lo_i == 2'b00 && ptr_wr_hi_i == 2'b00)
    |=> ($stable(ptr0_o) && $stable(ptr1_o)))
    else $error("pointer changed without a write");

  // main scenarios
  c_irq:   cover property (@(posedge ref_clk_i) fetch_cmd_i == 3'b100);
  c_brw:   cover property (@(posedge ref_clk_i) fetch_cmd_i == 3'b011);
  c_pmrd:  cover property (@(posedge ref_clk_i) wreg_load_o);
  c_wrap:  cover property (@(posedge ref_clk_i) pc_q == LAST_A ##1 pc_q == 15'h0000);
  c_jump:  cover property (@(posedge ref_clk_i) fetch_cmd_i == 3'b010);

endmodule

// ### design/pm_access_pkg.sv
package pm_access_pkg;

  // ----------------------------------------------------------------
  // program space
  // ----------------------------------------------------------------
  localparam int          PC_W          = 15;
  localparam int          WORD_W        = 14;
  localparam int          DATA_W        = 8;
  localparam int          PTR_W         = 16;
  localparam int          DEPTH_DEF     = 4096;
  localparam logic [14:0] RESET_VECTOR  = 15'h0000;
  localparam logic [14:0] INT_VECTOR    = 15'h0004;
  localparam int          PM_SEL_BIT    = 15;
  localparam logic [7:0]  PTR_RST       = 8'h00;
  localparam logic [7:0]  WREG_RST      = 8'h00;
  localparam int          PTR_COUNT     = 2;

  // ----------------------------------------------------------------
  // fetch commands and indirect read states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CMD_NONE  = 3'b000,
    CMD_STEP  = 3'b001,
    CMD_JUMP  = 3'b010,
    CMD_BRW   = 3'b011,
    CMD_IRQ   = 3'b100
  } fetch_cmd_e;

  typedef enum logic [1:0] {
    ST_RUN    = 2'b00,
    ST_PMREAD = 2'b01,
    ST_DONE   = 2'b10
  } rd_state_e;

endpackage

// ### design/pc_wrap.sv
`timescale 1ns/1ps
module pc_wrap #(
  parameter int DEPTH = pm_access_pkg::DEPTH_DEF
) (
  input  wire logic [14:0] addr_i,
  output logic      [14:0] addr_o
);

  // ----------------------------------------------------------------
  // wrap into implemented space
  // ----------------------------------------------------------------
  localparam logic [14:0] LAST = 15'(DEPTH - 1);

  initial
  begin
    if (DEPTH != 4096 && DEPTH != 8192 && DEPTH != 16384)
      $error("pc_wrap: depth must be 4096, 8192 or 16384");
  end

  // depth is a power of two, so masking equals modulo
  assign addr_o = addr_i & LAST;

endmodule

// ### design/ptr_reg.sv
`timescale 1ns/1ps
module ptr_reg (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        wr_lo_i,
  input  wire logic        wr_hi_i,
  input  wire logic [7:0]  wdata_i,
  output logic      [15:0] ptr_o
);

  // ----------------------------------------------------------------
  // one 16-bit file select pointer
  // ----------------------------------------------------------------
  logic [15:0] ptr_d;
  logic [15:0] ptr_q;

  // byte writes from the core
  always_comb
  begin
    ptr_d = ptr_q;
    if (wr_lo_i)
      ptr_d[7:0] = wdata_i;
    if (wr_hi_i)
      ptr_d[15:8] = wdata_i;
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      ptr_q <= {pm_access_pkg::PTR_RST, pm_access_pkg::PTR_RST};
    else
      ptr_q <= ptr_d;
  end

  assign ptr_o = ptr_q;

endmodule

// ### test/pm_model.sv
`timescale 1ns/1ps
module pm_model (
  input  wire logic [14:0] addr_i,
  input  wire logic        rd_i,
  output logic      [13:0] data_o
);
  // ------------------------------------------------
  // program word store
  // ------------------------------------------------
  // word is a fixed mix of address bits 7:0, so a wrong low address byte shows
  always_comb
  begin
    data_o = {addr_i[5:0], addr_i[7:0]} ^ 14'h2A55;
    if (!rd_i)
    begin
      data_o = ~data_o; // not read: never a stale word
    end
  end
endmodule

// ### test/tb_program_memory_access.sv
`timescale 1ns/1ps
module tb_program_memory_access;
  localparam int DEPTH = 4096;
  logic        ref_clk_i   = 1'b0;
  logic        rst_b_i     = 1'b0;
  logic [2:0]  fetch_cmd_i = 3'h0;
  logic [14:0] jump_addr_i = 15'h0000;
  logic [7:0]  wreg_i      = 8'h00;
  logic [1:0]  ptr_wr_lo_i = 2'h0;
  logic [1:0]  ptr_wr_hi_i = 2'h0;
  logic [7:0]  ptr_wdata_i = 8'h00;
  logic        ind_rd_i    = 1'b0;
  logic        ind_wr_i    = 1'b0;
  logic        ind_sel_i   = 1'b0;
  logic [13:0] pm_rdata;
  logic [14:0] pc_o;
  logic [14:0] pm_addr_o;
  logic        pm_rd_o;
  logic        fetch_stall_o;
  logic        ind_pm_o;
  logic        ind_wr_block_o;
  logic [7:0]  wreg_load_data_o;
  logic        wreg_load_o;
  logic [15:0] ptr0_o;
  logic [15:0] ptr1_o;
  int          bad_count   = 0;
  int          num_checks  = 0;

  always #5 ref_clk_i = ~ref_clk_i;

  program_memory_access #(.DEPTH(DEPTH)) program_memory_access_i (
    .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .fetch_cmd_i(fetch_cmd_i),
    .jump_addr_i(jump_addr_i), .wreg_i(wreg_i), .ptr_wr_lo_i(ptr_wr_lo_i),
    .ptr_wr_hi_i(ptr_wr_hi_i), .ptr_wdata_i(ptr_wdata_i), .ind_rd_i(ind_rd_i),
    .ind_wr_i(ind_wr_i), .ind_sel_i(ind_sel_i), .pm_rdata_i(pm_rdata),
    .pc_o(pc_o), .pm_addr_o(pm_addr_o), .pm_rd_o(pm_rd_o),
    .fetch_stall_o(fetch_stall_o), .ind_pm_o(ind_pm_o),
    .ind_wr_block_o(ind_wr_block_o), .wreg_load_data_o(wreg_load_data_o),
    .wreg_load_o(wreg_load_o), .ptr0_o(ptr0_o), .ptr1_o(ptr1_o));

  pm_model pm_model_i (.addr_i(pm_addr_o), .rd_i(pm_rd_o), .data_o(pm_rdata));

  // ------------------------------------------------
  // shared tasks
  // ------------------------------------------------
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    num_checks++;
    if (s !== e)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask

  // command over one rising edge, then one idle edge so back-to-back calls never retoggle
  task automatic cmd(input logic [2:0] c, input logic [14:0] a);
    fetch_cmd_i = c;
    jump_addr_i = a;
    @(negedge ref_clk_i);
    fetch_cmd_i = 3'h0;
    @(negedge ref_clk_i);
  endtask

  task automatic wptr(input logic sel, input logic [15:0] v);
    ptr_wdata_i = v[7:0];
    ptr_wr_lo_i[sel] = 1'b1;
    @(negedge ref_clk_i);
    ptr_wr_lo_i = 2'h0;
    ptr_wr_hi_i[sel] = 1'b1;
    ptr_wdata_i = v[15:8];
    @(negedge ref_clk_i);
    ptr_wr_hi_i = 2'h0;
  endtask

  // a step is offered on both edges; the stalled one must be dropped
  task automatic pread(input logic sel, input logic [15:0] v);
    logic [14:0] a;
    logic [14:0] p0;
    logic [13:0] w;
    a = v[14:0] & 15'(DEPTH - 1);
    w = {a[5:0], a[7:0]} ^ 14'h2A55;
    wptr(sel, v);
    ind_sel_i = sel;
    #1;
    chk("ind_pm", 16'h1, 16'(ind_pm_o));
    p0 = pc_o;
    ind_rd_i = 1'b1;
    fetch_cmd_i = 3'h1;
    @(negedge ref_clk_i);
    ind_rd_i = 1'b0;
    chk("stall", 16'h1, 16'(fetch_stall_o));
    chk("pm_addr", 16'(a), 16'(pm_addr_o));
    chk("pm_rd", 16'h1, 16'(pm_rd_o));
    @(negedge ref_clk_i);
    fetch_cmd_i = 3'h0;
    chk("load", 16'h1, 16'(wreg_load_o));
    chk("load_data", 16'(w[7:0]), 16'(wreg_load_data_o));
    chk("pc_held", 16'(p0 + 15'h1), 16'(pc_o));
  endtask

  // ------------------------------------------------
  // scenarios
  // ------------------------------------------------
  task automatic t_flow();
    cmd(3'h2, 15'h1005);
    chk("pc_wrap", 16'h0005, 16'(pc_o));
    cmd(3'h2, 15'h7FFF);
    chk("pc_top", 16'h0FFF, 16'(pc_o));
    cmd(3'h1, 15'h0000);
    chk("pc_roll", 16'h0000, 16'(pc_o));
    cmd(3'h4, 15'h0000);
    chk("pc_irq", 16'h0004, 16'(pc_o));
    wreg_i = 8'h03;
    cmd(3'h3, 15'h0000);
    chk("pc_brw", 16'h0008, 16'(pc_o));
    wreg_i = 8'hFF;
    cmd(3'h3, 15'h0000);
    chk("pc_brw_max", 16'h0108, 16'(pc_o));
    $display("test flow done");
  endtask

  task automatic t_pmread();
    wptr(1'b1, 16'h8123);
    chk("ptr1", 16'h8123, ptr1_o);
    chk("ptr0", 16'h0000, ptr0_o);
    pread(1'b1, 16'h8123);
    pread(1'b1, 16'hF3C7);
    pread(1'b0, 16'h8ABC);
    $display("test pmread done");
  endtask

  task automatic t_wblock();
    ind_sel_i = 1'b1;
    ind_wr_i = 1'b1;
    #1;
    chk("wr_block", 16'h1, 16'(ind_wr_block_o));
    wptr(1'b0, 16'h0040);
    ind_sel_i = 1'b0;
    #1;
    chk("data_sel", 16'h0, 16'(ind_pm_o));
    chk("wr_pass", 16'h0, 16'(ind_wr_block_o));
    ind_wr_i = 1'b0;
    ind_rd_i = 1'b1;
    @(negedge ref_clk_i);
    ind_rd_i = 1'b0;
    chk("data_rd", 16'h0, 16'(fetch_stall_o));
    $display("test wblock done");
  endtask

  task automatic t_rst2();
    cmd(3'h2, 15'h0123);
    rst_b_i = 1'b0;
    #1;
    chk("pc_rst", 16'h0000, 16'(pc_o));
    chk("ptr1_rst", 16'h0000, ptr1_o);
    chk("ptr0_rst", 16'h0000, ptr0_o);
    chk("fetch_rst", 16'h0000, 16'(pm_addr_o));
    @(negedge ref_clk_i);
    rst_b_i = 1'b1;
    @(negedge ref_clk_i);
    chk("pc_resume", 16'h0000, 16'(pc_o));
    cmd(3'h1, 15'h0000);
    chk("pc_first", 16'h0001, 16'(pc_o));
    $display("test rst2 done");
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // a hung run is cut off and judged as failed
  initial
  begin
    #200us;
    bad_count++;
    give_verdict();
  end

  initial
  begin
    repeat (2) @(negedge ref_clk_i);
    chk("pc_reset", 16'h0000, 16'(pc_o));
    rst_b_i = 1'b1;
    @(negedge ref_clk_i);
    t_flow();
    t_pmread();
    t_wblock();
    t_rst2();
    give_verdict();
  end
endmodule
